// ---- logic/sdb_pkg.sv ----
// Purpose: Shared constants and carrier types for the frame threshold and
//          descriptor table base register set.
// Assumes: AHB-Lite slave with 32-bit data, one clock, synchronous reset.
// Notes:   Offsets are byte addresses within a 4 KB decode window.
package sdb_pkg;

  // ----------------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] SDB_HTRANS_IDLE = 2'h0;
  localparam logic [1:0] SDB_HTRANS_NONSEQ = 2'h2;
  localparam logic SDB_HRESP_OKAY = 1'h0;
  localparam logic [2:0] SDB_HSIZE_BYTE = 3'h0;
  localparam logic [2:0] SDB_HSIZE_HALF = 3'h1;
  localparam int SDB_DEC_W = 12;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] SDB_OFS_SOF_THRESHOLD = 12'h000;
  localparam logic [11:0] SDB_OFS_BASE_PAGE_LOW = 12'h004;
  localparam logic [11:0] SDB_OFS_BASE_PAGE_MID = 12'h008;
  localparam logic [11:0] SDB_OFS_BASE_PAGE_HIGH = 12'h00C;

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int SDB_THR_W = 8;
  localparam int SDB_LOW_W = 7;
  localparam int SDB_LOW_LSB = 1;
  localparam int SDB_MID_W = 8;
  localparam int SDB_HIGH_W = 8;
  localparam int SDB_ALIGN_W = 9;
  localparam int SDB_ADDR_W = 32;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] SDB_THR_RST = 8'h00;
  localparam logic [6:0] SDB_LOW_RST = 7'h00;
  localparam logic [7:0] SDB_MID_RST = 8'h00;
  localparam logic [7:0] SDB_HIGH_RST = 8'h00;

  // Threshold codes software is expected to use per largest packet size
  localparam logic [7:0] SDB_THR_PKT64 = 8'h4A;
  localparam logic [7:0] SDB_THR_PKT32 = 8'h2A;
  localparam logic [7:0] SDB_THR_PKT16 = 8'h1A;
  localparam logic [7:0] SDB_THR_PKT8 = 8'h12;

  typedef enum logic [2:0] {
    SDB_SEL_THR,
    SDB_SEL_LOW,
    SDB_SEL_MID,
    SDB_SEL_HIGH,
    SDB_SEL_NONE
  } sdb_sel_t;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } sdb_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } sdb_ahb_rsp_t;

  typedef struct packed {
    logic valid;
    logic [SDB_ALIGN_W-1:0] offset;
  } sdb_desc_req_t;

  typedef struct packed {
    logic valid;
    logic [SDB_ADDR_W-1:0] addr;
  } sdb_desc_rsp_t;

endpackage

// ---- logic/sdb_regs.sv ----
// Purpose: Frame threshold register and three-part descriptor table base
//          pointer, with descriptor address formation for the transfer engine.
// Assumes: Single clock, synchronous active-high reset, zero-wait AHB-Lite.
// Notes:   Read data is taken from next-state values so a read right after a
//          write to the same register returns the new value.
`timescale 1ns/1ps

// Summary of operation
// - Eight-bit threshold field, read/write, resets zero.
// - Bits 31 to 8 read zero, ignore writes.
// - Low page bits 7-1 give base 15-9.
// - Low page bit 0 always reads zero.
// - Mid page bits 7-0 give base 23-16.
// - High page bits 7-0 give base 31-24.
// - Base is 512-byte aligned, low nine zero.
// - Assembled base locates descriptor table in memory.
module sdb_regs
  import sdb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire sdb_ahb_req_t ahb_req,
  output sdb_ahb_rsp_t ahb_rsp,
  input wire sdb_desc_req_t desc_req,
  output sdb_desc_rsp_t desc_rsp,
  output logic [SDB_THR_W-1:0] frame_threshold_count,
  output logic [SDB_ADDR_W-1:0] buffer_descriptor_table
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [SDB_THR_W-1:0] thr;
    logic [SDB_LOW_W-1:0] table_base_low_bits;
    logic [SDB_MID_W-1:0] table_base_mid_bits;
    logic [SDB_HIGH_W-1:0] table_base_high_bits;
    logic wr_pend;
    sdb_sel_t wr_sel;
    logic [31:0] hrdata;
    logic desc_valid;
    logic [SDB_ADDR_W-1:0] desc_addr;
  } sdb_state_t;

  sdb_state_t state_reg;
  sdb_state_t state_next;

  // ----------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------
  function automatic sdb_sel_t decode_sel(input logic [31:0] addr);
    sdb_sel_t sel;
    sel = SDB_SEL_NONE;
    if (addr[31:SDB_DEC_W] == '0) begin
      case (addr[SDB_DEC_W-1:0])
        SDB_OFS_SOF_THRESHOLD: sel = SDB_SEL_THR;
        SDB_OFS_BASE_PAGE_LOW: sel = SDB_SEL_LOW;
        SDB_OFS_BASE_PAGE_MID: sel = SDB_SEL_MID;
        SDB_OFS_BASE_PAGE_HIGH: sel = SDB_SEL_HIGH;
        default: sel = SDB_SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  // Narrow accesses only reach the fields when they cover byte lane 0
  function automatic logic lane0_hit(input logic [2:0] size,
                                     input logic [1:0] lo);
    logic hit;
    hit = 1'b1;
    if (size == SDB_HSIZE_BYTE || size == SDB_HSIZE_HALF) begin
      hit = (lo == 2'h0);
    end
    return hit;
  endfunction

  function automatic logic [31:0] read_word(input sdb_sel_t sel,
                                            input sdb_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (sel)
      SDB_SEL_THR: w[SDB_THR_W-1:0] = s.thr;
      SDB_SEL_LOW: w[SDB_LOW_LSB +: SDB_LOW_W] = s.table_base_low_bits;
      SDB_SEL_MID: w[SDB_MID_W-1:0] = s.table_base_mid_bits;
      SDB_SEL_HIGH: w[SDB_HIGH_W-1:0] = s.table_base_high_bits;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  logic addr_phase;
  sdb_sel_t addr_sel;
  logic [SDB_ADDR_W-1:0] table_base;

  always_comb begin
    state_next = state_reg;
    addr_sel = decode_sel(ahb_req.haddr);
    addr_phase = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];

    // Data phase of a write: only the implemented bits are kept
    if (state_reg.wr_pend) begin
      case (state_reg.wr_sel)
        SDB_SEL_THR: state_next.thr = ahb_req.hwdata[SDB_THR_W-1:0];
        SDB_SEL_LOW: begin
          state_next.table_base_low_bits =
            ahb_req.hwdata[SDB_LOW_LSB +: SDB_LOW_W];
        end
        SDB_SEL_MID: begin
          state_next.table_base_mid_bits = ahb_req.hwdata[SDB_MID_W-1:0];
        end
        SDB_SEL_HIGH: begin
          state_next.table_base_high_bits = ahb_req.hwdata[SDB_HIGH_W-1:0];
        end
        default: state_next.thr = state_reg.thr;
      endcase
    end

    // Address phase: capture writes, prepare read data from the updated copy
    state_next.wr_pend = 1'b0;
    state_next.wr_sel = SDB_SEL_NONE;
    if (addr_phase) begin
      if (ahb_req.hwrite) begin
        state_next.wr_pend = lane0_hit(ahb_req.hsize, ahb_req.haddr[1:0]);
        state_next.wr_sel = addr_sel;
      end else begin
        state_next.hrdata = read_word(addr_sel, state_next);
      end
    end

    // Descriptor addresses always use the live pointer fields
    table_base = {state_reg.table_base_high_bits,
                  state_reg.table_base_mid_bits,
                  state_reg.table_base_low_bits,
                  {SDB_ALIGN_W{1'b0}}};
    state_next.desc_valid = desc_req.valid;
    if (desc_req.valid) begin
      state_next.desc_addr = table_base | {{(SDB_ADDR_W-SDB_ALIGN_W){1'b0}},
                                           desc_req.offset};
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg.thr <= SDB_THR_RST;
      state_reg.table_base_low_bits <= SDB_LOW_RST;
      state_reg.table_base_mid_bits <= SDB_MID_RST;
      state_reg.table_base_high_bits <= SDB_HIGH_RST;
      state_reg.wr_pend <= 1'b0;
      state_reg.wr_sel <= SDB_SEL_NONE;
      state_reg.hrdata <= 32'h0000_0000;
      state_reg.desc_valid <= 1'b0;
      state_reg.desc_addr <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Zero-wait slave: every access completes in its first data-phase cycle
  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hresp = SDB_HRESP_OKAY;
  assign ahb_rsp.hrdata = state_reg.hrdata;
  assign desc_rsp.valid = state_reg.desc_valid;
  assign desc_rsp.addr = state_reg.desc_addr;
  assign frame_threshold_count = state_reg.thr;
  assign buffer_descriptor_table = {state_reg.table_base_high_bits,
                                    state_reg.table_base_mid_bits,
                                    state_reg.table_base_low_bits,
                                    {SDB_ALIGN_W{1'b0}}};

endmodule

// ---- test/sdb_regs_checker.sv ----
// Purpose: Port assertions for the register set
// Assumes: Word writes only
// Notes: Bound to every sdb_regs instance
`timescale 1ns/1ps
module sdb_regs_checker
  import sdb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire sdb_ahb_req_t ahb_req,
  input wire sdb_ahb_rsp_t ahb_rsp,
  input wire sdb_desc_req_t desc_req,
  input wire sdb_desc_rsp_t desc_rsp,
  input wire logic [SDB_THR_W-1:0] frame_threshold_count,
  input wire logic [SDB_ADDR_W-1:0] buffer_descriptor_table
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Address phase then data phase of a write
  sequence wr_to(logic [11:0] a);
    ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1] && ahb_req.hwrite
      && ahb_req.haddr == {20'h00000, a} ##1 1'b1;
  endsequence
  a_thr_write: assert property (wr_to(SDB_OFS_SOF_THRESHOLD) |=>
    frame_threshold_count == $past(ahb_req.hwdata[7:0])) else $error("threshold write lost");
  a_low_write: assert property (wr_to(SDB_OFS_BASE_PAGE_LOW) |=>
    buffer_descriptor_table[15:9] == $past(ahb_req.hwdata[7:1])) else $error("low page lost");
  a_mid_write: assert property (wr_to(SDB_OFS_BASE_PAGE_MID) |=>
    buffer_descriptor_table[23:16] == $past(ahb_req.hwdata[7:0])) else $error("mid page lost");
  a_high_write: assert property (wr_to(SDB_OFS_BASE_PAGE_HIGH) |=>
    buffer_descriptor_table[31:24] == $past(ahb_req.hwdata[7:0])) else $error("high page lost");
  a_base_align: assert property (buffer_descriptor_table[8:0] == 9'h000)
    else $error("base not aligned");
  a_rd_upper: assert property (ahb_rsp.hrdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_desc_addr: assert property (desc_req.valid |=> desc_rsp.valid &&
    desc_rsp.addr == ($past(buffer_descriptor_table) | 32'($past(desc_req.offset))))
    else $error("descriptor address wrong");
  a_desc_quiet: assert property (!desc_req.valid |=> !desc_rsp.valid)
    else $error("spurious descriptor answer");
endmodule

bind sdb_regs sdb_regs_checker i_sdb_regs_checker (.clk(clk), .rst(rst), .ahb_req(ahb_req),
  .ahb_rsp(ahb_rsp), .desc_req(desc_req), .desc_rsp(desc_rsp),
  .frame_threshold_count(frame_threshold_count),
  .buffer_descriptor_table(buffer_descriptor_table));

// ---- test/sdb_mem_model.sv ----
// Purpose: Memory side fetching descriptors
// Assumes: One request per go pulse
// Notes: Idle offset lines toggle so stale values never pass
`timescale 1ns/1ps
module sdb_mem_model
  import sdb_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic [SDB_ALIGN_W-1:0] off,
  output sdb_desc_req_t desc_req,
  input wire sdb_desc_rsp_t desc_rsp,
  output logic [SDB_ADDR_W-1:0] got
);
  // ----------------------------------------------------------------
  // Fetch
  // ----------------------------------------------------------------
  initial desc_req = '0;
  initial got = 32'h00000000;
  always @(posedge clk) begin
    desc_req.valid <= go;
    desc_req.offset <= go ? off : ~desc_req.offset;
    if (desc_rsp.valid) begin
      got <= desc_rsp.addr;
    end
  end
endmodule

// ---- test/usb_sof_threshold_and_descriptor_base_tb_top.sv ----
// Purpose: Self-checking bench for the register set
// Assumes: Zero-wait slave, word transfers except one byte write at lane 0
// Notes: Random data from a fixed xorshift seed
`timescale 1ns/1ps
module usb_sof_threshold_and_descriptor_base_tb_top;
  import sdb_pkg::*;
  // ----------------------------------------------------------------
  // Environment
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic [8:0] off = 9'h000;
  sdb_ahb_req_t bus = '0;
  sdb_ahb_req_t req;
  sdb_ahb_rsp_t rsp;
  sdb_desc_req_t dq;
  sdb_desc_rsp_t ds;
  logic [7:0] fcnt;
  logic [7:0] thr = 8'h00;
  logic [7:0] mid = 8'h00;
  logic [7:0] hi = 8'h00;
  logic [6:0] lo = 7'h00;
  logic [31:0] base_q, got, rd, d;
  logic [2:0] sz = 3'h2;
  logic [31:0] seed = 32'h00000063;
  logic [31:0] adr [6] = '{32'h0, 32'h4, 32'h8, 32'hC, 32'h10, 32'h1000};
  logic [7:0] codes [4] = '{SDB_THR_PKT64, SDB_THR_PKT32, SDB_THR_PKT16, SDB_THR_PKT8};
  int errors = 0;
  int check_count = 0;
  always #2.5 clk = ~clk;
  always_comb begin
    req = bus;
    req.hready = rsp.hreadyout;
  end
  sdb_regs i_sdb_regs (.clk(clk), .rst(rst), .ahb_req(req), .ahb_rsp(rsp), .desc_req(dq),
    .desc_rsp(ds), .frame_threshold_count(fcnt), .buffer_descriptor_table(base_q));
  sdb_mem_model i_sdb_mem_model (.clk(clk), .go(go), .off(off), .desc_req(dq),
    .desc_rsp(ds), .got(got));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] exp_rd(logic [31:0] a);
    if (a[31:12] != 20'h00000) return 32'h00000000;
    case (a[11:0])
      SDB_OFS_SOF_THRESHOLD: return {24'h000000, thr};
      SDB_OFS_BASE_PAGE_LOW: return {24'h000000, lo, 1'b0};
      SDB_OFS_BASE_PAGE_MID: return {24'h000000, mid};
      SDB_OFS_BASE_PAGE_HIGH: return {24'h000000, hi};
      default: return 32'h00000000;
    endcase
  endfunction
  task automatic results();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // Bounded wait for hready at a rising edge
  task automatic rdy();
    int i;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (rsp.hreadyout === 1'b1) break;
    end
    if (i == 16) begin
      errors++;
      results();
    end
  endtask
  task automatic xfer(logic w, logic [31:0] a, logic [31:0] dt);
    bus.haddr <= a;
    bus.htrans <= SDB_HTRANS_NONSEQ;
    bus.hwrite <= w;
    bus.hsize <= sz;
    rdy();
    bus.htrans <= SDB_HTRANS_IDLE;
    bus.hwdata <= dt;
    rdy();
    rd = rsp.hrdata;
    if (w && a[31:12] == 20'h00000) case (a[11:0])
      SDB_OFS_SOF_THRESHOLD: thr = dt[7:0];
      SDB_OFS_BASE_PAGE_LOW: lo = dt[7:1];
      SDB_OFS_BASE_PAGE_MID: mid = dt[7:0];
      SDB_OFS_BASE_PAGE_HIGH: hi = dt[7:0];
      default: ;
    endcase
  endtask
  task automatic rchk(logic [31:0] a);
    xfer(1'b0, a, xs());
    chk("hrdata", exp_rd(a), rd);
    chk("hresp", 32'(SDB_HRESP_OKAY), 32'(rsp.hresp));
  endtask
  task automatic dchk(logic [8:0] o);
    off <= o;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    chk("desc", {hi, mid, lo, 9'h000} | 32'(o), got);
    chk("base", {hi, mid, lo, 9'h000}, base_q);
    chk("thr", {24'h000000, thr}, {24'h000000, fcnt});
  endtask
  task automatic check_all();
    foreach (adr[k]) rchk(adr[k]);
    dchk(9'h1FF);
  endtask
  // ----------------------------------------------------------------
  // Sequence: reset values, suggested codes, random traffic, reset
  // ----------------------------------------------------------------
  initial begin
    bus.hsel <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check_all();
    foreach (codes[k]) begin
      xfer(1'b1, 32'h0, {24'hFFFFFF, codes[k]});
      rchk(32'h0);
    end
    // Byte write at lane 0 reaches the field like a word write
    sz = SDB_HSIZE_BYTE;
    xfer(1'b1, 32'h0, xs());
    sz = 3'h2;
    rchk(32'h0);
    repeat (60) begin
      d = adr[xs() % 6];
      xfer(1'b1, d, xs());
      rchk(d);
      rchk(adr[xs() % 6]);
      d = xs();
      dchk(d[8:0]);
    end
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    {thr, mid, hi, lo} = '0;
    @(posedge clk);
    check_all();
    results();
  end
endmodule
